// ---- rtl/usb_irq_defines.svh ----
// constants for the usb otg interrupt flag block: offsets, bit positions, timing
// assumes inclusion from the top module usb_irq_flags only; the package does not include it
//
// Summary of operation
// - id input change sets id_change_flag until software clears it.
// - each 1 ms timer expiry sets ms_timer_flag.
// - line state steady 1 ms and different from last stable state sets line_stable_flag.
// - activity on data lines or supply sense sets bus_activity_flag.
// - supply crossing a-session-end threshold either way sets session_valid_change_flag.
// - as b-device, supply crossing b-session-end sets b_session_end_flag.
// - as a-device, supply crossing a-supply-valid sets a_supply_valid_flag.
// - supply flags set on rising and falling crossings alike.
// - hardware sets flags; write one clears, zero keeps; all reset to zero.
// - otg enable bit per otg flag lets it raise the interrupt.
// - sending a stall handshake sets stall_sent_flag.
// - k state held 2.5 us sets resume_flag; k is taken as not se0 and not j at either speed.
// - bus idle 3 ms or longer sets idle_flag.
// - token completion sets token_done_flag; status readable in transfer_status_reg.
// - clearing token_done_flag advances the transfer status fifo.
// - received frame-start token or host threshold sets frame_start_flag.
// - error_summary_flag is read-only, set while any enabled error flag is set.
// - device mode: reset held 2.5 us sets bus_reset_flag once per reset.
// - host mode: not se0 and no activity for 2.5 us sets attach_flag.
// - host mode: bit 0 is detach_flag, set again only after reset clears.
// - bus event enable register masks each bus flag bit for bit.
`ifndef USB_IRQ_DEFINES_SVH
`define USB_IRQ_DEFINES_SVH

// register word offsets (byte addresses)
`define OFS_OTG_FLAGS     8'h00
`define OFS_OTG_ENABLES   8'h04
`define OFS_BUS_FLAGS     8'h08
`define OFS_BUS_ENABLES   8'h0C
`define OFS_XFER_STATUS   8'h10
`define OFS_ERR_FLAGS     8'h14
`define OFS_ERR_ENABLES   8'h18
`define OFS_MODE          8'h1C

// implemented bit masks
`define OTG_MASK          8'hFD
`define BUS_MASK_DEV      8'hBD
`define BUS_MASK_HOST     8'hFD
`define ERR_MASK          8'hBF

// bit positions
`define BIT_ID            3'd7
`define BIT_MS            3'd6
`define BIT_LSTATE        3'd5
`define BIT_ACTV          3'd4
`define BIT_SESVD         3'd3
`define BIT_SESEND        3'd2
`define BIT_VBUSVD        3'd0
`define BIT_STALL         3'd7
`define BIT_ATTACH        3'd6
`define BIT_RESUME        3'd5
`define BIT_IDLE          3'd4
`define BIT_TOKEN         3'd3
`define BIT_SOF           3'd2
`define BIT_ERR           3'd1
`define BIT_RST           3'd0

// timing at 125 MHz (8 ns)
`define CLK_PERIOD_PS     32'd8000
`define T_MS_PS           32'd1000000000
`define T_KSTATE_PS       32'd2500000
`define T_IDLE_PS         32'd3000000000
`define CYC_MS            (`T_MS_PS / `CLK_PERIOD_PS)
`define CYC_25US          ((`T_KSTATE_PS + `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define CYC_IDLE          (`T_IDLE_PS / `CLK_PERIOD_PS)

// transfer status fifo depth
`define XFER_DEPTH        4
`define XFER_PTR_W        2

`endif

// ---- rtl/usb_irq_pkg.sv ----
// types for the usb otg interrupt flag block
// assumes usb_irq_defines.svh sits on the include path
package usb_irq_pkg;
    // wishbone request as seen by the slave
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // raw line and supply indications, asynchronous; synchronised inside usb_irq_flags
    typedef struct packed {
        logic id;
        logic se0;
        logic j_state_indication;
        logic dline_act;
        logic a_sess_end;
        logic b_sess_end;
        logic a_vbus_vld;
    } line_t;

    // one-cycle events from the protocol engine
    typedef struct packed {
        logic       stall_sent;
        logic       token_done;
        logic [7:0] token_status;
        logic       sof_seen;
        logic       detach_seen;
    } proto_ev_t;

    typedef enum logic [1:0] {
        RST_IDLE,
        RST_TIMING,
        RST_FLAGGED
    } rst_state_t;
endpackage : usb_irq_pkg

// ---- rtl/usb_irq_flags.sv ----
// usb otg interrupt status and enable logic with a wishbone classic slave
// assumes line pins are asynchronous; protocol events come from logic on clk
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "usb_irq_defines.svh"

module usb_irq_flags
    import usb_irq_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire wb_req_t   wb_req,
    output logic           wb_ack,
    output logic [31:0]    wb_dat_o,
    input  wire line_t     line_pins,
    input  wire proto_ev_t proto_ev,
    input  wire logic [7:0] err_events,
    output logic           irq
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    line_t line_meta;
    line_t line_s;
    line_t line_q;
    logic [3:0] sync_fill;

    // three stages before any logic looks at the pins
    // sync_fill walks a one in behind reset so edge detectors know when samples are real
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_meta <= '0;
            line_s    <= '0;
            line_q    <= '0;
            sync_fill <= '0;
        end else begin
            line_meta <= line_pins;
            line_s    <= line_meta;
            line_q    <= line_s;
            sync_fill <= {sync_fill[2:0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] otg_event_flags;
    logic [7:0] otg_event_enables;
    logic [7:0] bus_flags;
    logic [7:0] bus_enables;
    logic [7:0] err_flags;
    logic [7:0] error_enable_reg;
    logic       host_mode;
    logic       low_speed;
    logic [7:0] next_otg_event_flags;
    logic [7:0] next_otg_event_enables;
    logic [7:0] next_bus_flags;
    logic [7:0] next_bus_enables;
    logic [7:0] next_err_flags;
    logic [7:0] next_error_enable_reg;
    logic       next_host_mode;
    logic       next_low_speed;
    // bus request decode, used by the fifo pop as well as the register write
    logic       req;
    logic       wr_otg_flags;
    logic       wr_bus_flags;
    logic       wr_err_flags;

    // ------------------------------------------------------------
    // timers
    // ------------------------------------------------------------
    logic [16:0] ms_cnt;
    logic [16:0] next_ms_cnt;
    logic        ms_tick;
    logic [8:0]  k_cnt;
    logic [8:0]  next_k_cnt;
    logic [8:0]  quiet_cnt;
    logic [8:0]  next_quiet_cnt;
    logic [18:0] idle_cnt;
    logic [18:0] next_idle_cnt;
    logic        idle_done;
    logic        next_idle_done;
    logic [1:0]  lstate_cur;
    logic [1:0]  lstate_stable;
    logic [1:0]  next_lstate_stable;
    logic [16:0] lstate_cnt;
    logic [16:0] next_lstate_cnt;
    logic        attach_done;
    logic        next_attach_done;
    logic [8:0]  rst_cnt;
    logic [8:0]  next_rst_cnt;
    rst_state_t  rst_state;
    rst_state_t  next_rst_state;
    logic        detach_armed;
    logic        next_detach_armed;
    // previous samples for the edge detectors, and the token queue controls
    logic        id_prev;
    logic        aend_prev;
    logic        bend_prev;
    logic        vbus_prev;
    logic [2:0]  fifo_cnt;
    logic        fifo_pop;
    logic        fifo_push;

    // saturating step toward a limit
    function automatic logic [18:0] step(input logic [18:0] v, input logic [18:0] lim);
        step = (v >= lim) ? lim : v + 19'h0_0001;
    endfunction : step

    // k state ignores speed: not se0 and not j, low_speed unused
    logic k_state;
    logic bus_j;
    assign bus_j   = line_q.j_state_indication;
    assign k_state = ~line_q.se0 & ~bus_j;
    assign ms_tick = (ms_cnt == 17'(`CYC_MS - 1));
    assign lstate_cur = {line_q.se0, bus_j};

    // timer next-state
    always_comb begin
        next_ms_cnt        = ms_tick ? 17'h0_0000 : ms_cnt + 17'h0_0001;
        next_k_cnt         = k_state ? 9'(step(19'(k_cnt), 19'(`CYC_25US))) : 9'h000;
        next_quiet_cnt     = (line_q.dline_act | line_q.se0) ? 9'h000
                             : 9'(step(19'(quiet_cnt), 19'(`CYC_25US)));
        next_idle_cnt      = (line_q.dline_act | ~bus_j | line_q.se0) ? 19'h0_0000
                             : step(idle_cnt, 19'(`CYC_IDLE));
        // one pulse when the count first reaches its limit, not on every saturated cycle
        next_idle_done     = (next_idle_cnt == 19'(`CYC_IDLE)) && (idle_cnt != 19'(`CYC_IDLE));
        next_attach_done   = (next_quiet_cnt == 9'(`CYC_25US)) && (quiet_cnt != 9'(`CYC_25US));
        next_rst_cnt       = line_q.se0 ? 9'(step(19'(rst_cnt), 19'(`CYC_25US))) : 9'h000;
        next_rst_state     = rst_state;
        unique case (rst_state)
            RST_IDLE:    if (line_q.se0) next_rst_state = RST_TIMING;
            RST_TIMING:  if (!line_q.se0) next_rst_state = RST_IDLE;
                         else if (rst_cnt == 9'(`CYC_25US)) next_rst_state = RST_FLAGGED;
            RST_FLAGGED: if (!line_q.se0) next_rst_state = RST_IDLE;
        endcase
        next_detach_armed  = detach_armed;
        if (proto_ev.detach_seen)
            next_detach_armed = 1'b0;
        else if (!line_q.se0)
            next_detach_armed = 1'b1;
    end

    // the prev copies are only trusted once line_q has real samples behind it,
    // else reset zeros against an idle-high pin would look like a change
    logic edges_ok;
    assign edges_ok = sync_fill[3];

    logic [1:0] lstate_last;
    logic [1:0] next_lstate_last;
    logic       lstate_hit;
    assign lstate_hit = (lstate_cnt == 17'(`CYC_MS - 1));

    always_comb begin
        next_lstate_last   = lstate_cur;
        next_lstate_stable = lstate_stable;
        if (lstate_cur != lstate_last)
            next_lstate_cnt = 17'h0_0000;
        else if (lstate_hit)
            next_lstate_cnt = lstate_cnt;
        else
            next_lstate_cnt = lstate_cnt + 17'h0_0001;
        // record the new stable state only in the cycle the flag fires for it
        if (lstate_hit && (lstate_cur == lstate_last) && (lstate_cur != lstate_stable))
            next_lstate_stable = lstate_cur;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ms_cnt        <= '0;
            k_cnt         <= '0;
            quiet_cnt     <= '0;
            idle_cnt      <= '0;
            idle_done     <= 1'b0;
            attach_done   <= 1'b0;
            rst_cnt       <= '0;
            rst_state     <= RST_IDLE;
            detach_armed  <= 1'b0;
            lstate_cnt    <= '0;
            lstate_last   <= '0;
            lstate_stable <= '0;
        end else begin
            ms_cnt        <= next_ms_cnt;
            k_cnt         <= next_k_cnt;
            quiet_cnt     <= next_quiet_cnt;
            idle_cnt      <= next_idle_cnt;
            idle_done     <= next_idle_done;
            attach_done   <= next_attach_done;
            rst_cnt       <= next_rst_cnt;
            rst_state     <= next_rst_state;
            detach_armed  <= next_detach_armed;
            lstate_cnt    <= next_lstate_cnt;
            lstate_last   <= next_lstate_last;
            lstate_stable <= next_lstate_stable;
        end
    end

    // ------------------------------------------------------------
    // hardware set events
    // ------------------------------------------------------------
    logic [7:0] otg_set;
    logic [7:0] bus_set;
    logic       stable_change;
    logic       resume_ev;
    logic       reset_ev;
    assign stable_change = lstate_hit && (lstate_cur == lstate_last)
                           && (lstate_cur != lstate_stable);
    assign resume_ev = (k_cnt == 9'(`CYC_25US - 1)) & k_state;
    assign reset_ev  = (rst_state == RST_TIMING) && line_q.se0
                       && (rst_cnt == 9'(`CYC_25US));

    always_comb begin
        otg_set = 8'h00;
        otg_set[`BIT_ID]     = edges_ok & (id_prev ^ line_q.id);
        otg_set[`BIT_MS]     = ms_tick;
        otg_set[`BIT_LSTATE] = stable_change;
        otg_set[`BIT_ACTV]   = line_q.dline_act
                               | (edges_ok & (vbus_prev ^ line_q.a_vbus_vld));
        otg_set[`BIT_SESVD]  = edges_ok & (aend_prev ^ line_q.a_sess_end);
        otg_set[`BIT_SESEND] = edges_ok & ~line_q.id & (bend_prev ^ line_q.b_sess_end);
        otg_set[`BIT_VBUSVD] = edges_ok & line_q.id & (vbus_prev ^ line_q.a_vbus_vld);
        bus_set = 8'h00;
        bus_set[`BIT_STALL]  = proto_ev.stall_sent;
        bus_set[`BIT_ATTACH] = host_mode & attach_done;
        bus_set[`BIT_RESUME] = resume_ev;
        bus_set[`BIT_IDLE]   = idle_done;
        // popping the last entry lets the clear win; with more queued the flag stays
        bus_set[`BIT_TOKEN]  = fifo_push | (fifo_pop & (fifo_cnt > 3'd1));
        bus_set[`BIT_SOF]    = proto_ev.sof_seen;
        bus_set[`BIT_RST]    = host_mode ? (proto_ev.detach_seen & detach_armed)
                                         : (~host_mode & reset_ev);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            id_prev   <= 1'b0;
            aend_prev <= 1'b0;
            bend_prev <= 1'b0;
            vbus_prev <= 1'b0;
        end else begin
            id_prev   <= line_q.id;
            aend_prev <= line_q.a_sess_end;
            bend_prev <= line_q.b_sess_end;
            vbus_prev <= line_q.a_vbus_vld;
        end
    end

    // ------------------------------------------------------------
    // transfer status fifo
    // ------------------------------------------------------------
    logic [7:0]             fifo_mem [`XFER_DEPTH];
    logic [`XFER_PTR_W-1:0] rd_ptr;
    logic [`XFER_PTR_W-1:0] wr_ptr;
    assign fifo_push = proto_ev.token_done && (fifo_cnt != 3'(`XFER_DEPTH));
    // clearing the token flag pops the shown entry so the next one appears
    assign fifo_pop  = wr_bus_flags && wb_req.dat[`BIT_TOKEN] && (fifo_cnt != 3'd0);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ptr   <= '0;
            wr_ptr   <= '0;
            fifo_cnt <= '0;
            for (int i = 0; i < `XFER_DEPTH; i++) fifo_mem[i] <= 8'h00;
        end else begin
            if (fifo_push) begin
                fifo_mem[wr_ptr] <= proto_ev.token_status;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (fifo_pop) rd_ptr <= rd_ptr + 1'b1;
            fifo_cnt <= fifo_cnt + 3'(fifo_push) - 3'(fifo_pop);
        end
    end

    // ------------------------------------------------------------
    // wishbone slave: ack one cycle after request, dropped next cycle
    // ------------------------------------------------------------
    assign req          = wb_req.cyc & wb_req.stb & ~wb_ack;
    assign wr_otg_flags = req & wb_req.we & wb_req.sel[0] && wb_req.adr == `OFS_OTG_FLAGS;
    assign wr_bus_flags = req & wb_req.we & wb_req.sel[0] && wb_req.adr == `OFS_BUS_FLAGS;
    assign wr_err_flags = req & wb_req.we & wb_req.sel[0] && wb_req.adr == `OFS_ERR_FLAGS;

    // write-one-clear with set winning over the clear
    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                       input logic clr_en, input logic [7:0] clr);
        w1c = (cur & ~(clr_en ? clr : 8'h00)) | set;
    endfunction : w1c

    logic wr_ctl;
    assign wr_ctl = req & wb_req.we & wb_req.sel[0];

    always_comb begin
        next_otg_event_flags   = w1c(otg_event_flags, otg_set, wr_otg_flags, wb_req.dat[7:0])
                                 & `OTG_MASK;
        next_bus_flags         = w1c(bus_flags, bus_set, wr_bus_flags, wb_req.dat[7:0])
                                 & (host_mode ? `BUS_MASK_HOST : `BUS_MASK_DEV);
        next_err_flags         = w1c(err_flags, err_events, wr_err_flags, wb_req.dat[7:0])
                                 & `ERR_MASK;
        next_otg_event_enables = otg_event_enables;
        next_bus_enables       = bus_enables;
        next_error_enable_reg  = error_enable_reg;
        next_host_mode         = host_mode;
        next_low_speed         = low_speed;
        if (wr_ctl && wb_req.adr == `OFS_OTG_ENABLES)
            next_otg_event_enables = wb_req.dat[7:0] & `OTG_MASK;
        if (wr_ctl && wb_req.adr == `OFS_BUS_ENABLES)
            next_bus_enables = wb_req.dat[7:0];
        if (wr_ctl && wb_req.adr == `OFS_ERR_ENABLES)
            next_error_enable_reg = wb_req.dat[7:0] & `ERR_MASK;
        if (wr_ctl && wb_req.adr == `OFS_MODE) begin
            next_host_mode = wb_req.dat[0];
            next_low_speed = wb_req.dat[1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            otg_event_flags   <= 8'h00;
            otg_event_enables <= 8'h00;
            bus_flags         <= 8'h00;
            bus_enables       <= 8'h00;
            err_flags         <= 8'h00;
            error_enable_reg  <= 8'h00;
            host_mode         <= 1'b0;
            low_speed         <= 1'b0;
        end else begin
            otg_event_flags   <= next_otg_event_flags;
            otg_event_enables <= next_otg_event_enables;
            bus_flags         <= next_bus_flags;
            bus_enables       <= next_bus_enables;
            err_flags         <= next_err_flags;
            error_enable_reg  <= next_error_enable_reg;
            host_mode         <= next_host_mode;
            low_speed         <= next_low_speed;
        end
    end

    // summary bit is computed, never stored, so writes cannot clear it
    logic       err_summary;
    logic [7:0] bus_view;
    assign err_summary = |(err_flags & error_enable_reg);
    assign bus_view    = (bus_flags & ~8'h02) | {6'h00, err_summary, 1'b0};

    // read mux, registered
    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_req.adr)
            `OFS_OTG_FLAGS:   next_rdata[7:0] = otg_event_flags;
            `OFS_OTG_ENABLES: next_rdata[7:0] = otg_event_enables;
            `OFS_BUS_FLAGS:   next_rdata[7:0] = bus_view;
            `OFS_BUS_ENABLES: next_rdata[7:0] = bus_enables
                                & (host_mode ? 8'hFF : 8'hBF);
            `OFS_XFER_STATUS: next_rdata[7:0] = (fifo_cnt != 3'd0) ? fifo_mem[rd_ptr]
                                                                 : 8'h00;
            `OFS_ERR_FLAGS:   next_rdata[7:0] = err_flags;
            `OFS_ERR_ENABLES: next_rdata[7:0] = error_enable_reg;
            `OFS_MODE:        next_rdata[7:0] = {6'h00, low_speed, host_mode};
            default:          next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack   <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack   <= req;
            wb_dat_o <= req ? next_rdata : 32'h0000_0000;
        end
    end

    // one level request from all enabled flag pairs
    assign irq = |(otg_event_flags & otg_event_enables)
               | |(bus_view & bus_enables);

endmodule : usb_irq_flags

// ---- dv/usb_irq_flags_assertions.sv ----
// port checker for usb_irq_flags, bound into every instance
// assumes one clock domain with rst asynchronous, active high
`timescale 1ns/1ps
module usb_irq_flags_assertions
    import usb_irq_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire wb_req_t     wb_req,
    input wire logic        wb_ack,
    input wire logic [31:0] wb_dat_o,
    input wire line_t       line_pins,
    input wire proto_ev_t   proto_ev,
    input wire logic [7:0]  err_events,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // bus handshake
    // ----
    logic req;
    assign req = wb_req.cyc && wb_req.stb && !wb_ack;
    a_ack_single:
        assert property (wb_ack |=> !wb_ack) else $error("ack held over one cycle");
    a_ack_latency:
        assert property (req |=> wb_ack) else $error("request not acked next cycle");
    a_ack_needs_req:
        assert property (!(wb_req.cyc && wb_req.stb) |=> !wb_ack) else $error("ack without request");
    a_read_upper_zero:
        assert property (wb_ack |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper data set");
    a_unmapped_zero:
        assert property (req && !wb_req.we && wb_req.adr > 8'h1C |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_misaligned_zero:
        assert property (req && !wb_req.we && wb_req.adr[1:0] != 2'h0 |=> wb_dat_o == 32'h0000_0000)
        else $error("misaligned read not zero");
    // ----
    // flags and request line
    // ----
    a_quiet_after_reset:
        assert property ($fell(rst) |-> !irq && !wb_ack) else $error("irq or ack after reset");
    // sticky flags only fall through a write, so irq drops only beside an ack
    a_irq_drop_write:
        assert property ($fell(irq) |-> wb_ack || $past(wb_ack)) else $error("irq fell without write");
endmodule : usb_irq_flags_assertions

bind usb_irq_flags usb_irq_flags_assertions u_usb_irq_flags_assertions (
    .clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
    .line_pins(line_pins), .proto_ev(proto_ev), .err_events(err_events), .irq(irq));

// ---- dv/usb_bus_model.sv ----
// usb bus side: line levels and protocol engine event pulses
// assumes the bench calls its tasks; all changes land just after a clk edge
`timescale 1ns/1ps
module usb_bus_model
    import usb_irq_pkg::*;
(
    input  wire logic  clk,
    output line_t      line_pins,
    output proto_ev_t  proto_ev,
    output logic [7:0] err_events
);
    // idle bus: j state, a-device, no supply thresholds crossed
    initial begin
        line_pins  = 7'h50;
        proto_ev   = '0;
        err_events = 8'h00;
    end
    task automatic set_pins(input line_t v);
        @(posedge clk);
        line_pins <= v;
    endtask : set_pins
    // events are one-cycle pulses, as the engine would give them
    task automatic pulse(input proto_ev_t p, input logic [7:0] e);
        @(posedge clk);
        proto_ev   <= p;
        err_events <= e;
        @(posedge clk);
        proto_ev   <= '0;
        err_events <= 8'h00;
    endtask : pulse
endmodule : usb_bus_model

// ---- dv/usb_irq_flags_tb.sv ----
// self-checking bench for usb_irq_flags over wishbone classic
// assumes usb_bus_model drives the line and event inputs
`timescale 1ns/1ps
module usb_irq_flags_tb;
    import usb_irq_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    wb_req_t     wb_req = '0;
    logic        wb_ack;
    logic [31:0] wb_dat_o;
    line_t       line_pins;
    proto_ev_t   proto_ev;
    logic [7:0]  err_events;
    logic        irq;
    int          n_fail = 0;
    int          check_count = 0;
    int          pb [7] = '{0, 0, 2, 2, 6, 1, 1};
    int          fb [7] = '{0, 0, 3, 3, 7, 2, 2};
    usb_irq_flags u_usb_irq_flags (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack),
        .wb_dat_o(wb_dat_o), .line_pins(line_pins), .proto_ev(proto_ev),
        .err_events(err_events), .irq(irq));
    usb_bus_model u_usb_bus_model (.clk(clk), .line_pins(line_pins), .proto_ev(proto_ev),
        .err_events(err_events));
    always #4 clk = ~clk;
    // ----
    // bus tasks
    // ----
    // request held until ack is seen high at a rising edge; released at that same edge
    task automatic wb_cycle(input logic we, input logic [7:0] a, d, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, {24'h00_0000, d}};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) cmp(32'h0000_0000, 32'h0000_0001);
        wb_req <= '0;
    endtask : wb_cycle
    task automatic wr(input logic [7:0] a, d);
        logic [31:0] x;
        wb_cycle(1'b1, a, d, x);
    endtask : wr
    task automatic cmp(input logic [31:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic rd_check(input logic [7:0] a, input logic [31:0] m, e);
        logic [31:0] rd;
        wb_cycle(1'b0, a, 8'h00, rd);
        cmp(rd & m, e);
    endtask : rd_check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // ----
    // tests
    // ----
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        wrap_up();
    end
    initial begin
        line_t      p;
        logic [7:0] f;
        p = 7'h50;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd_check(8'h00, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_check(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
        rd_check(8'h02, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h04, 8'hFF);
        rd_check(8'h04, 32'hFFFF_FFFF, 32'h0000_00FD);
        wr(8'h0C, 8'hFF);
        rd_check(8'h0C, 32'hFFFF_FFFF, 32'h0000_00BF);
        wr(8'h0C, 8'h80);
        $display("test registers done");
        // each supply line crosses both ways; id flips role from a- to b-device
        for (int i = 0; i < 7; i++) begin
            p[pb[i]] = ~p[pb[i]];
            u_usb_bus_model.set_pins(p);
            repeat (6) @(posedge clk);
            f = 8'h01 << fb[i];
            rd_check(8'h00, 32'h0000_00EF, {24'h00_0000, f});
            cmp({31'h0000_0000, irq}, 32'h0000_0001);
            wr(8'h00, ~f);
            rd_check(8'h00, 32'h0000_00EF, {24'h00_0000, f});
            wr(8'h00, f);
            rd_check(8'h00, 32'h0000_00EF, 32'h0000_0000);
        end
        p[3] = 1'b1;
        u_usb_bus_model.set_pins(p);
        p[3] = 1'b0;
        u_usb_bus_model.set_pins(p);
        repeat (6) @(posedge clk);
        rd_check(8'h00, 32'h0000_0010, 32'h0000_0010);
        wr(8'h00, 8'hFF);
        $display("test otg flags done");
        wr(8'h18, 8'h01);
        u_usb_bus_model.pulse(12'h802, 8'h05);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0086);
        cmp({31'h0000_0000, irq}, 32'h0000_0001);
        wr(8'h08, 8'h02);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0086);
        wr(8'h14, 8'h01);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0084);
        wr(8'h08, 8'h84);
        cmp({31'h0000_0000, irq}, 32'h0000_0000);
        u_usb_bus_model.pulse(12'h694, 8'h00);
        u_usb_bus_model.pulse(12'h4F0, 8'h00);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0008);
        rd_check(8'h10, 32'hFFFF_FFFF, 32'h0000_00A5);
        wr(8'h08, 8'h08);
        rd_check(8'h10, 32'hFFFF_FFFF, 32'h0000_003C);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0008);
        wr(8'h08, 8'h08);
        rd_check(8'h08, 32'hFFFF_FFFF, 32'h0000_0000);
        wr(8'h14, 8'hFF);
        $display("test bus events done");
        // bus reset held well past 313 cycles, then cleared while still held
        p[5] = 1'b1;
        u_usb_bus_model.set_pins(p);
        repeat (400) @(posedge clk);
        rd_check(8'h08, 32'h0000_0001, 32'h0000_0001);
        wr(8'h08, 8'h01);
        repeat (400) @(posedge clk);
        rd_check(8'h08, 32'h0000_0001, 32'h0000_0000);
        $display("test bus reset done");
        // reset ends straight into a k state, held past 313 cycles
        p[5] = 1'b0;
        p[4] = 1'b0;
        u_usb_bus_model.set_pins(p);
        repeat (400) @(posedge clk);
        rd_check(8'h08, 32'h0000_0020, 32'h0000_0020);
        p[4] = 1'b1;
        u_usb_bus_model.set_pins(p);
        wr(8'h08, 8'h20);
        // host mode: activity, then quiet past 313 cycles, then a detach event
        wr(8'h1C, 8'h01);
        p[3] = 1'b1;
        u_usb_bus_model.set_pins(p);
        p[3] = 1'b0;
        u_usb_bus_model.set_pins(p);
        repeat (400) @(posedge clk);
        u_usb_bus_model.pulse(12'h001, 8'h00);
        rd_check(8'h08, 32'h0000_0061, 32'h0000_0041);
        $display("test line events done");
        wrap_up();
    end
endmodule : usb_irq_flags_tb
